// ===== src/pbt_defs.svh
// What this block does
// RL1: bit 7 enables byte D23..16 compare
// RL2: bit 6 enables byte D31..24 compare
// RL3: data invert flips data comparator result
// RL4: address mode bits all zero disable
// RL5: bit 4 matches outside low-high range
// RL6: bit 3 matches inside inclusive range
// RL7: bit 2 matches address equal low bound
// RL8: bit 1 enables the PC breakpoint
// RL9: bit 0 selects inside or outside region
// RL10: valid bit gates unmasked PC comparands
// RL11: mask one bits ignore first comparand bits
// RL12: mask applies to first comparand only
// RL13: host writes mask before using first comparand
// RL14: unmasked comparands compare bits 31..1
// RL15: host clears bit 0 of first comparand
// RL16: host zeroes top address byte
// RL17: writes accepted in supervisor or debug port
// RL18: global enable gates every level-1 trigger
// RL19: bit 14 picks AND or OR combine
// RL20: one-cycle PC match per executed instruction
`ifndef PBT_DEFS_SVH
`define PBT_DEFS_SVH

// register selects on the link write path
`define PBT_SEL_TRIG      4'h0
`define PBT_SEL_PC_MASKED 4'h1
`define PBT_SEL_PC_VALID1 4'h2
`define PBT_SEL_PC_VALID3 4'h4
`define PBT_SEL_PC_MASK   4'h5
`define PBT_SEL_ADDR_LOW  4'h6
`define PBT_SEL_ADDR_HIGH 4'h7
`define PBT_SEL_DATA      4'h8

// trigger definition field positions
`define PBT_TDR_COMB_OP   14
`define PBT_TDR_GLOBAL_EN 13
`define PBT_TDR_LANE_LONG 12
`define PBT_TDR_LANE_LOW  11
`define PBT_TDR_LANE_UP   10
`define PBT_TDR_LANE_B0   9
`define PBT_TDR_DATA_INV  5
`define PBT_TDR_ADDR_OUT  4
`define PBT_TDR_ADDR_IN   3
`define PBT_TDR_ADDR_EQ   2
`define PBT_TDR_PC_EN     1
`define PBT_TDR_PC_INV    0

// comparand layout
`define PBT_VALID_BIT     0
`define PBT_TOP_BYTE_MASK 32'h00ff_ffff
`define PBT_BIT0_MASK     32'hffff_fffe
`define PBT_REG_RST       32'h0000_0000

// transfer size codes
`define PBT_SIZE_BYTE     2'h0
`define PBT_SIZE_WORD     2'h1
`define PBT_SIZE_LONG     2'h2

// host software register offsets and fields
`define PBT_HOFF_DATA     8'h00
`define PBT_HOFF_GO       8'h04
`define PBT_HOFF_STATUS   8'h08
`define PBT_GO_SUPV_BIT   4
`define PBT_ST_BUSY       0
`define PBT_ST_MASK_OK    1
`define PBT_ST_REFUSED    2
`define PBT_ST_TRIG_SEEN  3

`endif

// ===== src/pbt_pkg.sv
package pbt_pkg;

  // host command sequencer states
  typedef enum logic [0:0] {
    PBT_H_IDLE,
    PBT_H_BUSY
  } pbt_hstate_t;

  // whole state of the device end
  typedef struct packed {
    logic [31:0]       trigger_definition;
    logic [31:0]       pc_compare_masked;
    logic [2:0][31:0]  pbr_v;
    logic [31:0]       pc_compare_mask;
    logic [31:0]       addr_low_bound;
    logic [31:0]       addr_high_bound;
    logic [31:0]       data_comparand;
    logic              pc_hit;
    logic              ad_hit;
    logic              trig;
  } pbt_dev_state_t;

  // whole state of the host end
  typedef struct packed {
    pbt_hstate_t       st;
    logic [31:0]       data;
    logic [31:0]       rdata;
    logic              mask_ok;
    logic              refused;
    logic              trig_seen;
    logic [7:0]        trig_cnt;
    logic              wr;
    logic [3:0]        wsel;
    logic [31:0]       wdata;
    logic              wsupv;
    logic [31:0]       pc;
    logic              pc_valid;
    logic [31:0]       addr;
    logic [31:0]       dat;
    logic [1:0]        size;
    logic              xfer_valid;
  } pbt_host_state_t;

endpackage

// ===== src/pbt_if.sv
`timescale 1ns/10ps
`default_nettype none

interface pbt_if;
  // register write path
  logic        wr;
  logic [3:0]  wsel;
  logic [31:0] wdata;
  logic        wsupv;
  // core activity
  logic [31:0] pc;
  logic        pc_valid;
  logic [31:0] addr;
  logic [31:0] dat;
  logic [1:0]  size;
  logic        xfer_valid;
  // trigger results
  logic        trig;
  logic        pc_match;
  logic        ad_match;

  modport dev (
    input  wr, wsel, wdata, wsupv, pc, pc_valid, addr, dat, size, xfer_valid,
    output trig, pc_match, ad_match
  );

  modport host (
    output wr, wsel, wdata, wsupv, pc, pc_valid, addr, dat, size, xfer_valid,
    input  trig, pc_match, ad_match
  );
endinterface // pbt_if

`default_nettype wire

// ===== src/pbt_pc_cmp.sv
`timescale 1ns/10ps
`default_nettype none

module pbt_pc_cmp (
  // comparand setup
  input  wire logic [31:0] i_comparand,
  input  wire logic [31:0] i_mask,
  input  wire logic        i_enable,
  // program counter
  input  wire logic [31:0] i_pc,
  // result
  output logic             o_hit
);
  // masked bits never take part
  assign o_hit = i_enable && (((i_comparand ^ i_pc) & ~i_mask) == 32'h0000_0000); // RL11
endmodule // pbt_pc_cmp

`default_nettype wire

// ===== src/pbt_device.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "pbt_defs.svh"

module pbt_device
  import pbt_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // link to core and debug host
  pbt_if.dev        link,
  // user side trigger view
  output logic      o_trigger,
  output logic      o_pc_match,
  output logic      o_addr_match
);

  pbt_dev_state_t s;
  pbt_dev_state_t next_s;

  logic [3:0]  pc_hits;
  logic        pc_region;
  logic        pc_now;
  logic [3:0]  byte_eq;
  logic [3:0]  byte_place;
  logic [3:0]  byte_en;
  logic        up_eq;
  logic        low_eq;
  logic        long_eq;
  logic        data_en;
  logic        data_raw;
  logic        data_ok;
  logic        addr_eq;
  logic        addr_in;
  logic        addr_hit;
  logic        addr_en;
  logic        ad_now;
  logic        combined;

  // four PC comparators, the first one masked
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pc
      if (g == 0) begin : g_masked
        pbt_pc_cmp u_cmp (
          .i_comparand (s.pc_compare_masked),
          .i_mask      (s.pc_compare_mask),                               // RL12
          .i_enable    (1'b1),
          .i_pc        (link.pc),
          .o_hit       (pc_hits[g])
        );
      end else begin : g_valid
        pbt_pc_cmp u_cmp (
          .i_comparand (s.pbr_v[g-1]),
          .i_mask      (32'h0000_0001),                        // RL14
          .i_enable    (s.pbr_v[g-1][`PBT_VALID_BIT]),         // RL10
          .i_pc        (link.pc),
          .o_hit       (pc_hits[g])
        );
      end
    end
  endgenerate

  // pc condition from any comparand
  always_comb begin
    pc_region = |pc_hits;
    pc_now    = link.pc_valid                                  // RL20
                && s.trigger_definition[`PBT_TDR_PC_EN]                       // RL8
                && (pc_region ^ s.trigger_definition[`PBT_TDR_PC_INV]);       // RL9
  end

  // byte lanes, lane 0 is D7..0
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      assign byte_eq[g]    = link.dat[8*g+7 -: 8] == s.data_comparand[8*g+7 -: 8];
      assign byte_place[g] = (link.size == `PBT_SIZE_BYTE)
                             && (link.addr[1:0] == 2'(3 - g));
      assign byte_en[g]    = s.trigger_definition[`PBT_TDR_LANE_B0 - g];      // RL1 RL2
    end
  endgenerate

  // data condition over enabled lanes
  always_comb begin
    up_eq    = link.dat[31:16] == s.data_comparand[31:16];
    low_eq   = link.dat[15:0] == s.data_comparand[15:0];
    long_eq  = link.dat == s.data_comparand;
    data_en  = |s.trigger_definition[`PBT_TDR_LANE_LONG:`PBT_TDR_LANE_B0 - 3];
    data_raw = (|(byte_eq & byte_place & byte_en))
               || (s.trigger_definition[`PBT_TDR_LANE_UP] && up_eq
                   && (link.size == `PBT_SIZE_WORD) && !link.addr[1])
               || (s.trigger_definition[`PBT_TDR_LANE_LOW] && low_eq
                   && (link.size == `PBT_SIZE_WORD) && link.addr[1])
               || (s.trigger_definition[`PBT_TDR_LANE_LONG] && long_eq
                   && (link.size == `PBT_SIZE_LONG));
    // the invert bit flips the result whenever any lane is enabled; with no lane enabled it is true
    if (data_en) begin
      data_ok = data_raw ^ s.trigger_definition[`PBT_TDR_DATA_INV];          // RL3
    end else begin
      data_ok = 1'b1;
    end
  end

  // address condition by mode bits
  always_comb begin
    addr_eq  = link.addr == s.addr_low_bound;
    addr_in  = (link.addr >= s.addr_low_bound) && (link.addr <= s.addr_high_bound);
    addr_hit = (s.trigger_definition[`PBT_TDR_ADDR_EQ] && addr_eq)            // RL7
               || (s.trigger_definition[`PBT_TDR_ADDR_IN] && addr_in)         // RL6
               || (s.trigger_definition[`PBT_TDR_ADDR_OUT] && !addr_in);      // RL5
    addr_en  = |s.trigger_definition[`PBT_TDR_ADDR_OUT:`PBT_TDR_ADDR_EQ];     // RL4
    ad_now   = link.xfer_valid && addr_en && addr_hit && data_ok;
  end

  // level-1 combine of pc and address terms
  always_comb begin
    if (s.trigger_definition[`PBT_TDR_COMB_OP]) begin
      combined = pc_now || ad_now;                             // RL19
    end else begin
      combined = pc_now && ad_now;                             // RL19
    end
  end

  // next state: register writes and match pulses
  always_comb begin
    next_s        = s;
    next_s.pc_hit = pc_now;                                    // RL20
    next_s.ad_hit = ad_now;
    next_s.trig   = s.trigger_definition[`PBT_TDR_GLOBAL_EN] && combined;     // RL18
    // writes from supervisor or debug port only
    if (link.wr && link.wsupv) begin                           // RL17
      case (link.wsel)
        `PBT_SEL_TRIG: begin
          next_s.trigger_definition = link.wdata;
        end
        `PBT_SEL_PC_MASKED: begin
          next_s.pc_compare_masked = link.wdata;
        end
        `PBT_SEL_PC_VALID1: begin
          next_s.pbr_v[0] = link.wdata;
        end
        `PBT_SEL_PC_VALID1 + 4'h1: begin
          next_s.pbr_v[1] = link.wdata;
        end
        `PBT_SEL_PC_VALID3: begin
          next_s.pbr_v[2] = link.wdata;
        end
        `PBT_SEL_PC_MASK: begin
          next_s.pc_compare_mask = link.wdata;
        end
        `PBT_SEL_ADDR_LOW: begin
          next_s.addr_low_bound = link.wdata;
        end
        `PBT_SEL_ADDR_HIGH: begin
          next_s.addr_high_bound = link.wdata;
        end
        `PBT_SEL_DATA: begin
          next_s.data_comparand = link.wdata;
        end
        default: begin
          next_s.data_comparand = s.data_comparand;                                  // unmapped, ignored
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s.trigger_definition    <= `PBT_REG_RST;
      s.pc_compare_masked   <= `PBT_REG_RST;
      s.pbr_v  <= {3{`PBT_REG_RST}};
      s.pc_compare_mask   <= `PBT_REG_RST;
      s.addr_low_bound   <= `PBT_REG_RST;
      s.addr_high_bound   <= `PBT_REG_RST;
      s.data_comparand    <= `PBT_REG_RST;
      s.pc_hit <= 1'b0;
      s.ad_hit <= 1'b0;
      s.trig   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign link.trig     = s.trig;
  assign link.pc_match = s.pc_hit;
  assign link.ad_match = s.ad_hit;
  assign o_trigger     = s.trig;
  assign o_pc_match    = s.pc_hit;
  assign o_addr_match  = s.ad_hit;

endmodule // pbt_device

`default_nettype wire

// ===== src/pbt_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbt_defs.svh"

module pbt_host
  import pbt_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // software register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // core activity
  input  wire logic [31:0] i_pc,
  input  wire logic        i_pc_valid,
  input  wire logic [31:0] i_baddr,
  input  wire logic [31:0] i_bdata,
  input  wire logic [1:0]  i_bsize,
  input  wire logic        i_xfer_valid,
  // link to device
  pbt_if.host              link
);

  pbt_host_state_t s;
  pbt_host_state_t next_s;
  logic [3:0]      go_sel;
  logic [31:0]     clean;
  logic [31:0]     status;

  // sanitise outgoing register data
  always_comb begin
    go_sel = i_wdata[3:0];
    clean  = s.data;
    if (go_sel != `PBT_SEL_TRIG && go_sel != `PBT_SEL_PC_MASK
        && go_sel != `PBT_SEL_DATA) begin
      clean = clean & `PBT_TOP_BYTE_MASK;                      // RL16
    end
    if (go_sel == `PBT_SEL_PC_MASKED) begin
      clean = clean & `PBT_BIT0_MASK;                          // RL15
    end
    status = 32'h0000_0000;
    status[`PBT_ST_BUSY]      = s.st == PBT_H_BUSY;
    status[`PBT_ST_MASK_OK]   = s.mask_ok;
    status[`PBT_ST_REFUSED]   = s.refused;
    status[`PBT_ST_TRIG_SEEN] = s.trig_seen;
    status[15:8]              = s.trig_cnt;
  end

  // sequencer, software registers, core capture
  always_comb begin
    next_s            = s;
    next_s.wr         = 1'b0;
    next_s.rdata      = 32'h0000_0000;
    next_s.pc         = i_pc;
    next_s.pc_valid   = i_pc_valid;
    next_s.addr       = i_baddr;
    next_s.dat        = i_bdata;
    next_s.size       = i_bsize;
    next_s.xfer_valid = i_xfer_valid;
    case (s.st)
      PBT_H_IDLE: begin
        next_s.st = PBT_H_IDLE;
      end
      PBT_H_BUSY: begin
        next_s.st = PBT_H_IDLE;
      end
      default: begin
        next_s.st = PBT_H_IDLE;
      end
    endcase
    if (i_rd) begin
      case (i_addr)
        `PBT_HOFF_DATA:   next_s.rdata = s.data;
        `PBT_HOFF_STATUS: next_s.rdata = status;
        default:          next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (i_wr && i_addr == `PBT_HOFF_DATA) begin
      next_s.data = i_wdata;
    end
    if (i_wr && i_addr == `PBT_HOFF_STATUS) begin
      if (i_wdata[`PBT_ST_REFUSED]) next_s.refused = 1'b0;
      if (i_wdata[`PBT_ST_TRIG_SEEN]) next_s.trig_seen = 1'b0;
    end
    // a go while busy, or a first comparand go before the mask is written, is refused
    if (i_wr && i_addr == `PBT_HOFF_GO) begin
      if (s.st == PBT_H_BUSY
          || (go_sel == `PBT_SEL_PC_MASKED && !s.mask_ok)) begin // RL13
        next_s.refused = 1'b1;
      end else begin
        next_s.st    = PBT_H_BUSY;
        next_s.wr    = 1'b1;
        next_s.wsel  = go_sel;
        next_s.wdata = clean;
        next_s.wsupv = i_wdata[`PBT_GO_SUPV_BIT];              // RL17
        if (go_sel == `PBT_SEL_PC_MASK) next_s.mask_ok = 1'b1; // RL13
      end
    end
    // set wins over a clear in the same cycle
    if (link.trig) begin
      next_s.trig_seen = 1'b1;
      next_s.trig_cnt  = s.trig_cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // link and read data from flops
  assign o_rdata         = s.rdata;
  assign link.wr         = s.wr;
  assign link.wsel       = s.wsel;
  assign link.wdata      = s.wdata;
  assign link.wsupv      = s.wsupv;
  assign link.pc         = s.pc;
  assign link.pc_valid   = s.pc_valid;
  assign link.addr       = s.addr;
  assign link.dat        = s.dat;
  assign link.size       = s.size;
  assign link.xfer_valid = s.xfer_valid;

endmodule // pbt_host

`default_nettype wire

// ===== sim/pbt_sva.sv
`timescale 1ns/10ps
`default_nettype none

module pbt_sva (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // link signals
  input  wire logic        wr,
  input  wire logic [3:0]  wsel,
  input  wire logic [31:0] wdata,
  input  wire logic        wsupv,
  input  wire logic [31:0] pc,
  input  wire logic        pc_valid,
  input  wire logic [31:0] addr,
  input  wire logic        xfer_valid,
  input  wire logic        trig,
  input  wire logic        pc_match,
  input  wire logic        ad_match
);
  logic [31:0] trigger_definition;
  logic [31:0] pc_compare_masked;
  logic [31:0] pc_compare_mask;
  logic [31:0] alo;

  // mirror of the device registers the checks need
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trigger_definition  <= 32'h0;
      pc_compare_masked <= 32'h0;
      pc_compare_mask <= 32'h0;
      alo  <= 32'h0;
    end else if (wr && wsupv) begin
      case (wsel)
        4'h0: trigger_definition <= wdata;
        4'h1: pc_compare_masked <= wdata;
        4'h5: pc_compare_mask <= wdata;
        4'h6: alo <= wdata;
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // instruction inside the masked first comparand region
  sequence s_pc0_hit;
    pc_valid && trigger_definition[1] && (((pc ^ pc_compare_masked) & ~pc_compare_mask) == 32'h0);
  endsequence
  // transfer at the low bound, equal mode, no data lanes
  sequence s_addr_eq;
    xfer_valid && trigger_definition[2] && (trigger_definition[12:6] == 7'h0) && (addr == alo);
  endsequence

  a_pc_needs_valid: assert property (pc_match |-> $past(pc_valid))
    else $error("pc match without instruction");
  a_pc_enable_gate: assert property (pc_match |-> $past(trigger_definition[1]))
    else $error("pc match while disabled");
  a_pc0_region: assert property (s_pc0_hit |=> pc_match != $past(trigger_definition[0]))
    else $error("masked comparand result wrong");
  a_ad_needs_xfer: assert property (ad_match |-> $past(xfer_valid))
    else $error("address match without transfer");
  a_addr_mode_off: assert property (ad_match |-> $past(trigger_definition[4:2]) != 3'h0)
    else $error("address match with modes off");
  a_addr_eq_hit: assert property (s_addr_eq |=> ad_match)
    else $error("equal address missed");
  a_global_gate: assert property (trig |-> $past(trigger_definition[13]))
    else $error("trigger while globally disabled");
  a_combine_op: assert property ($past(trigger_definition[13]) |->
    trig == ($past(trigger_definition[14]) ? (pc_match || ad_match) : (pc_match && ad_match)))
    else $error("trigger combine wrong");
endmodule // pbt_sva

`default_nettype wire

// ===== sim/pbt_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbt_defs.svh"

module pbt_tb;
  logic        i_clk, i_rst_n, i_wr, i_rd, i_pc_valid, i_xfer_valid, e;
  logic        o_trigger, o_pc_match, o_addr_match;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, i_pc, i_baddr, i_bdata, v, a;
  logic [1:0]  i_bsize;
  int          bad_count, comparisons, k, m, j;
  logic [31:0] ta [5] = '{32'h0ff, 32'h100, 32'h150, 32'h1ff, 32'h200};

  pbt_if pbt_if_i ();
  pbt_host pbt_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pc(i_pc), .i_pc_valid(i_pc_valid),
    .i_baddr(i_baddr), .i_bdata(i_bdata), .i_bsize(i_bsize), .i_xfer_valid(i_xfer_valid),
    .link(pbt_if_i));
  pbt_device pbt_device_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(pbt_if_i),
    .o_trigger(o_trigger), .o_pc_match(o_pc_match), .o_addr_match(o_addr_match));
  pbt_sva pbt_sva_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .wr(pbt_if_i.wr), .wsel(pbt_if_i.wsel),
    .wdata(pbt_if_i.wdata), .wsupv(pbt_if_i.wsupv), .pc(pbt_if_i.pc),
    .pc_valid(pbt_if_i.pc_valid), .addr(pbt_if_i.addr), .xfer_valid(pbt_if_i.xfer_valid),
    .trig(pbt_if_i.trig), .pc_match(pbt_if_i.pc_match), .ad_match(pbt_if_i.ad_match));

  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= ad;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // load one device register through the host
  task automatic prog(input logic [3:0] sel, input logic [31:0] d, input logic su);
    wr(`PBT_HOFF_DATA, d);
    wr(`PBT_HOFF_GO, {27'h0, su, sel});
    repeat (2) @(posedge i_clk);
  endtask

  // one core cycle, result checked two edges later
  task automatic core(input logic [31:0] p, input logic pv, input logic [31:0] ad,
                      input logic [31:0] d, input logic [1:0] sz, input logic xv,
                      input logic [2:0] exp);
    @(posedge i_clk);
    i_pc         <= p;
    i_pc_valid   <= pv;
    i_baddr      <= ad;
    i_bdata      <= d;
    i_bsize      <= sz;
    i_xfer_valid <= xv;
    @(posedge i_clk);
    i_pc_valid   <= 1'b0;
    i_xfer_valid <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({29'h0, o_trigger, o_pc_match, o_addr_match}, {29'h0, exp});
  endtask

  task automatic summarize;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    {i_rst_n, i_wr, i_rd, i_pc_valid, i_xfer_valid, i_addr, i_bsize} = '0;
    {i_wdata, i_pc, i_baddr, i_bdata} = '0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(`PBT_HOFF_STATUS, 32'h0);
    rd(8'h0c, 32'h0);
    prog(4'h1, 32'h0000_1200, 1'b1);
    rd(`PBT_HOFF_STATUS, 32'h4);
    wr(`PBT_HOFF_STATUS, 32'h4);
    prog(4'h5, 32'h0000_00ff, 1'b1);
    rd(`PBT_HOFF_DATA, 32'h0000_00ff);
    prog(4'h1, 32'hff00_1200, 1'b1);
    rd(`PBT_HOFF_STATUS, 32'h2);
    prog(4'h0, 32'h0000_6002, 1'b1);
    core(32'h12f4, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b110);
    core(32'h1300, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b000);
    core(32'h12f4, 1'b0, 32'h0, 32'h0, 2'h2, 1'b0, 3'b000);
    prog(4'h0, 32'h0000_6003, 1'b1);
    core(32'h12f4, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b000);
    core(32'h5000, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b110);
    prog(4'h0, 32'h0000_4002, 1'b1);
    core(32'h12f4, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b010);
    prog(4'h0, 32'h0000_6002, 1'b1);
    for (k = 2; k <= 4; k++) begin
      v = {16'h0, 4'h6, k[3:0], 8'h01};
      prog(k[3:0], v, 1'b1);
      core({v[31:1], 1'b0}, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b110);
      core(v + 32'h0f, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b000);
      prog(k[3:0], v ^ 32'h1, 1'b1);
      core({v[31:1], 1'b0}, 1'b1, 32'h0, 32'h0, 2'h2, 1'b0, 3'b000);
    end
    prog(4'h6, 32'h0000_0100, 1'b1);
    prog(4'h7, 32'h0000_01ff, 1'b1);
    for (m = 0; m < 4; m++) begin
      prog(4'h0, 32'h0000_6000 | ((m == 0) ? 32'h0 : (32'h2 << m)), 1'b1);
      for (j = 0; j < 5; j++) begin
        a = ta[j];
        e = (m == 1 && a == 32'h100) || (m == 2 && a >= 32'h100 && a <= 32'h1ff) ||
            (m == 3 && (a < 32'h100 || a > 32'h1ff));
        core(32'h0, 1'b0, a, 32'h0, 2'h2, 1'b1, {e, 1'b0, e});
      end
    end
    prog(4'h8, 32'ha5c3_0000, 1'b1);
    prog(4'h0, 32'h0000_6048, 1'b1);
    core(32'h0, 1'b0, 32'h100, 32'ha500_0000, 2'h0, 1'b1, 3'b101);
    core(32'h0, 1'b0, 32'h100, 32'h5a00_0000, 2'h0, 1'b1, 3'b000);
    prog(4'h0, 32'h0000_6068, 1'b1);
    core(32'h0, 1'b0, 32'h100, 32'ha500_0000, 2'h0, 1'b1, 3'b000);
    core(32'h0, 1'b0, 32'h100, 32'h5a00_0000, 2'h0, 1'b1, 3'b101);
    prog(4'h0, 32'h0000_6088, 1'b1);
    core(32'h0, 1'b0, 32'h101, 32'h00c3_0000, 2'h0, 1'b1, 3'b101);
    core(32'h0, 1'b0, 32'h101, 32'h003c_0000, 2'h0, 1'b1, 3'b000);
    prog(4'h0, 32'h0000_200a, 1'b1);
    core(32'h12f4, 1'b1, 32'h150, 32'h0, 2'h2, 1'b1, 3'b111);
    core(32'h12f4, 1'b1, 32'h150, 32'h0, 2'h2, 1'b0, 3'b010);
    core(32'h0, 1'b0, 32'h150, 32'h0, 2'h2, 1'b1, 3'b001);
    prog(4'h0, 32'h0, 1'b0);
    core(32'h12f4, 1'b1, 32'h150, 32'h0, 2'h2, 1'b1, 3'b111);
    // sixteen trigger pulses so far, mask written, trigger seen
    rd(`PBT_HOFF_STATUS, 32'h0000_100a);
    summarize();
  end
endmodule // pbt_tb

`default_nettype wire
